// ### masx_core.sv
// masx_core: accumulator, file registers, status flags, sleep and watchdog
// assumes an avalon-mm master on mclk_i; one access at a time
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`include "masx_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module masx_core #(
	parameter int PRE_W = 7,
	parameter int WDT_W = 8,
	parameter int FILE_DEPTH = 128
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [`MASX_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic sleep_o,
	output logic osc_en_o,
	output logic wdt_timeout_o
);

	// core state
	logic [7:0] acc;
	logic [7:0] next_acc;
	masx_pkg::masx_flags_t flags;
	masx_pkg::masx_flags_t next_flags;
	masx_pkg::masx_state_t state;
	masx_pkg::masx_state_t next_state;
	logic next_sleep;
	logic next_osc_en;
	logic [7:0] fmem [FILE_DEPTH];
	logic f_we;
	logic [6:0] f_waddr;
	logic [7:0] f_wdata;

	// watchdog state
	logic [PRE_W-1:0] pre_cnt;
	logic [PRE_W-1:0] next_pre_cnt;
	logic [WDT_W-1:0] wdt_cnt;
	logic [WDT_W-1:0] next_wdt_cnt;
	logic next_wdt_timeout;
	logic wdt_expire;
	logic sleep_exec;

	// bus state
	logic [31:0] next_readdata;
	logic next_waitrequest;

	// decode
	masx_pkg::masx_cmd_t cmd;
	logic wr_take;
	logic rd_first;
	logic exec;
	logic [6:0] ex_addr;
	logic [6:0] bus_fidx;
	logic bus_file;
	logic [7:0] fval;
	logic [7:0] swapped;
	logic [8:0] sub_full;
	logic [4:0] sub_lo;
	logic [7:0] sub_val;
	logic sub_c;
	logic sub_dc;
	logic [7:0] xl_res;
	logic [7:0] xf_res;
	logic [7:0] ex_res;
	logic [2:0] arith_flags;
	logic [1:0] cdc_flags;
	logic [31:0] rd_mux;

	// a write lands only at the edge where waitrequest is seen low
	assign wr_take = avs_write_i && !avs_waitrequest_o;
	assign rd_first = avs_read_i && avs_waitrequest_o;
	assign cmd = masx_pkg::masx_cmd_t'(avs_writedata_i[`MASX_CMD_W-1:0]);
	assign bus_file = avs_address_i[`MASX_FILE_SEL];
	assign bus_fidx = avs_address_i[`MASX_FILE_IDX_MSB:`MASX_FILE_IDX_LSB];
	assign ex_addr = cmd.faddr;
	assign fval = fmem[ex_addr];

	// instructions run only while awake; a halted core ignores commands
	assign exec = wr_take && !bus_file && (avs_address_i == `MASX_OFF_CMD)
		&& ((avs_byteenable_i & `MASX_CMD_BE) == `MASX_CMD_BE)
		&& (state == masx_pkg::masx_run);

	assign swapped = {fval[`MASX_NIB_W-1:0], fval[7:`MASX_NIB_W]};

	// two's complement, carry means no borrow
	assign sub_full = {1'b0, cmd.lit} + {1'b0, ~acc} + 9'h001;
	assign sub_lo = {1'b0, cmd.lit[`MASX_NIB_W-1:0]} + {1'b0, ~acc[`MASX_NIB_W-1:0]} + 5'h01;
	assign sub_val = sub_full[7:0];
	assign sub_c = sub_full[8];
	assign sub_dc = sub_lo[`MASX_NIB_W];

	assign xl_res = acc ^ cmd.lit;
	assign xf_res = acc ^ fval;
	assign ex_res = (cmd.op == masx_pkg::masx_nibble_exchange_op) ? swapped : xf_res;
	assign arith_flags = flags[`MASX_ARITH_MSB:0];
	assign cdc_flags = flags[`MASX_CDC_MSB:0];

	// wrap of both stages is the watchdog time-out
	assign wdt_expire = (&pre_cnt) && (&wdt_cnt);

	// read mux, unmapped words read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (bus_file) begin
			rd_mux = 32'(fmem[bus_fidx]);
		end else begin
			case (avs_address_i)
				`MASX_OFF_ACC: rd_mux = 32'(acc);
				`MASX_OFF_STATUS: rd_mux = 32'(flags);
				`MASX_OFF_POWER: rd_mux = 32'({wdt_cnt, pre_cnt, sleep_o});
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// bus handshake: one wait cycle, then a single cycle with waitrequest low
	always_comb begin
		next_waitrequest = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		next_readdata = avs_readdata_o;
		if (rd_first) begin
			next_readdata = rd_mux;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			avs_waitrequest_o <= `MASX_WAIT_RST;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= next_waitrequest;
			avs_readdata_o <= next_readdata;
		end
	end

	// core next state: command execution, register writes, wake-up
	always_comb begin
		next_acc = acc;
		next_flags = flags;
		next_state = state;
		next_sleep = sleep_o;
		next_osc_en = osc_en_o;
		f_we = 1'b0;
		f_waddr = ex_addr;
		f_wdata = ex_res;
		sleep_exec = 1'b0;
		if (exec) begin
			case (cmd.op)
				masx_pkg::masx_nibble_exchange_op: begin
					if (cmd.dest == `MASX_DEST_FILE) begin
						f_we = 1'b1;
					end else begin
						next_acc = swapped;
					end
				end
				masx_pkg::masx_literal_minus_acc_op: begin
					next_acc = sub_val;
					next_flags.carry_flag = sub_c;
					next_flags.nibble_carry_flag = sub_dc;
					next_flags.zero_flag = (sub_val == 8'h00);
				end
				masx_pkg::masx_literal_xor_op: begin
					next_acc = xl_res;
					next_flags.zero_flag = (xl_res == 8'h00);
				end
				masx_pkg::masx_acc_file_xor_op: begin
					if (cmd.dest == `MASX_DEST_FILE) begin
						f_we = 1'b1;
					end else begin
						next_acc = xf_res;
					end
					next_flags.zero_flag = (xf_res == 8'h00);
				end
				masx_pkg::masx_sleep_op: begin
					next_flags.power_down_flag = 1'b0;
					next_flags.time_out_flag = 1'b1;
					next_state = masx_pkg::masx_asleep;
					next_sleep = 1'b1;
					next_osc_en = 1'b0;
					sleep_exec = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (wr_take && avs_byteenable_i[`MASX_LANE0]) begin
			// software may load acc, arithmetic flags and file words; pd/to stay read-only
			if (bus_file) begin
				f_we = 1'b1;
				f_waddr = bus_fidx;
				f_wdata = avs_writedata_i[`MASX_BYTE_MSB:0];
			end else if (avs_address_i == `MASX_OFF_ACC) begin
				next_acc = avs_writedata_i[`MASX_BYTE_MSB:0];
			end else if (avs_address_i == `MASX_OFF_STATUS) begin
				next_flags.zero_flag = avs_writedata_i[`MASX_Z_BIT];
				next_flags.nibble_carry_flag = avs_writedata_i[`MASX_DC_BIT];
				next_flags.carry_flag = avs_writedata_i[`MASX_C_BIT];
			end
		end
		// a time-out clears the time-out flag unless a sleep sets it this very cycle
		if (wdt_expire && !sleep_exec) begin
			next_flags.time_out_flag = 1'b0;
		end
		// wake from a software request or a watchdog time-out
		if (state == masx_pkg::masx_asleep && (wdt_expire || (wr_take
			&& avs_address_i == `MASX_OFF_POWER && avs_writedata_i[`MASX_PWR_WAKE]))) begin
			next_state = masx_pkg::masx_run;
			next_sleep = 1'b0;
			next_osc_en = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			acc <= `MASX_ACC_RST;
			flags <= masx_pkg::masx_flags_t'(`MASX_FLAGS_RST);
			state <= masx_pkg::masx_run;
			sleep_o <= 1'b0;
			osc_en_o <= 1'b1;
		end else begin
			acc <= next_acc;
			flags <= next_flags;
			state <= next_state;
			sleep_o <= next_sleep;
			osc_en_o <= next_osc_en;
		end
	end

	// file array has no reset, contents are undefined until written
	always_ff @(posedge mclk_i) begin
		if (f_we) begin
			fmem[f_waddr] <= f_wdata;
		end
	end

	// watchdog: prescaler feeds counter, both keep running in sleep
	always_comb begin
		next_pre_cnt = pre_cnt + PRE_W'(1);
		next_wdt_cnt = (&pre_cnt) ? wdt_cnt + WDT_W'(1) : wdt_cnt;
		next_wdt_timeout = wdt_expire && !sleep_exec;
		if (sleep_exec) begin
			next_pre_cnt = '0;
			next_wdt_cnt = '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pre_cnt <= '0;
			wdt_cnt <= '0;
			wdt_timeout_o <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			wdt_cnt <= next_wdt_cnt;
			wdt_timeout_o <= next_wdt_timeout;
		end
	end

	// checks: each ties a command to its effect one edge later, except a_file_addr_hit, which checks the same cycle
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_exec(masx_pkg::masx_op_t o);
		exec && (cmd.op == o);
	endsequence

	sequence s_asleep_still;
		sleep_o && !osc_en_o;
	endsequence

	a_sleep_status: assert property (
		s_exec(masx_pkg::masx_sleep_op) |=> flags.time_out_flag && !flags.power_down_flag)
		else $error("sleep did not set time-out and clear power-down");

	a_sleep_wdt_clear: assert property (
		s_exec(masx_pkg::masx_sleep_op) |=> (pre_cnt == '0 && wdt_cnt == '0)
		##1 (pre_cnt == PRE_W'(1)))
		else $error("watchdog not cleared by sleep");

	a_sleep_osc_halt: assert property (
		s_exec(masx_pkg::masx_sleep_op) |=> s_asleep_still ##1 (s_asleep_still or !sleep_o))
		else $error("oscillator still running after sleep");

	a_swap_to_acc: assert property (
		s_exec(masx_pkg::masx_nibble_exchange_op) and (cmd.dest == `MASX_DEST_ACC)
		|=> acc == $past(swapped))
		else $error("nibble exchange result wrong");

	a_swap_flags_kept: assert property (
		s_exec(masx_pkg::masx_nibble_exchange_op) |=> $stable(arith_flags))
		else $error("nibble exchange changed a flag");

	a_dest_to_file: assert property (
		exec && cmd.dest == `MASX_DEST_FILE && (cmd.op == masx_pkg::masx_nibble_exchange_op
		|| cmd.op == masx_pkg::masx_acc_file_xor_op)
		|=> acc == $past(acc) && fmem[$past(ex_addr)] == $past(ex_res))
		else $error("file destination not honoured");

	a_file_addr_hit: assert property (
		exec && cmd.dest == `MASX_DEST_FILE && (cmd.op == masx_pkg::masx_nibble_exchange_op
		|| cmd.op == masx_pkg::masx_acc_file_xor_op)
		|-> f_we && f_waddr == avs_writedata_i[`MASX_FADDR_MSB:`MASX_FADDR_LSB])
		else $error("file write went to wrong address");

	a_sub_result: assert property (
		s_exec(masx_pkg::masx_literal_minus_acc_op) |=> acc == $past(sub_val)
		&& flags.carry_flag == $past(sub_c) && flags.nibble_carry_flag == $past(sub_dc))
		else $error("literal minus accumulator wrong");

	a_xorl_result: assert property (
		s_exec(masx_pkg::masx_literal_xor_op) |=> acc == $past(xl_res) && $stable(cdc_flags))
		else $error("literal xor wrong");

	a_xorf_result: assert property (
		s_exec(masx_pkg::masx_acc_file_xor_op) and (cmd.dest == `MASX_DEST_ACC)
		|=> acc == $past(xf_res) && $stable(cdc_flags))
		else $error("file xor wrong");

	a_zero_flag: assert property (
		(s_exec(masx_pkg::masx_literal_minus_acc_op) or s_exec(masx_pkg::masx_literal_xor_op))
		|=> flags.zero_flag == (acc == 8'h00))
		else $error("zero flag disagrees with result");

endmodule : masx_core

`default_nettype wire

// ### masx_defs.svh
// masx_defs.svh: register map, field limits and reset values of the alu/sleep block
// assumes byte addressing on a 32-bit avalon-mm slave port
//
// What this block does
// - sleep clears the power-down flag and sets the time-out flag
// - sleep clears the watchdog counter and its prescaler
// - after sleep the core idles with its oscillator stopped
// - nibble exchange moves source low nibble high and high nibble low
// - nibble exchange leaves carry, nibble carry and zero flags untouched
// - destination bit 0 writes the accumulator, 1 writes the file register
// - file operand is a 7-bit address 0 to 127 plus a destination bit
// - literal minus accumulator goes to accumulator, updating carry, nibble carry, zero
// - literal xor with accumulator goes to accumulator, updating only zero
// - accumulator xor file goes to chosen destination, updating only zero
`ifndef MASX_DEFS_SVH
`define MASX_DEFS_SVH

`define MASX_ADDR_W 10
`define MASX_OFF_ACC 10'h000
`define MASX_OFF_STATUS 10'h004
`define MASX_OFF_CMD 10'h008
`define MASX_OFF_POWER 10'h00c
`define MASX_FILE_SEL 9
`define MASX_FILE_IDX_MSB 8
`define MASX_FILE_IDX_LSB 2
`define MASX_CMD_W 24
`define MASX_CMD_BE 4'h7
`define MASX_LANE0 0
`define MASX_ARITH_MSB 2
`define MASX_CDC_MSB 1
`define MASX_PWR_WAKE 0
`define MASX_NIB_W 4
`define MASX_BYTE_MSB 7
`define MASX_Z_BIT 2
`define MASX_DC_BIT 1
`define MASX_C_BIT 0
`define MASX_FADDR_MSB 10
`define MASX_FADDR_LSB 4
`define MASX_ACC_RST 8'h00
`define MASX_FLAGS_RST 5'h18
`define MASX_WAIT_RST 1'b1
`define MASX_DEST_ACC 1'b0
`define MASX_DEST_FILE 1'b1

`endif

// ### masx_pkg.sv
// masx_pkg: types shared by the alu/sleep block
// assumes masx_defs.svh supplies the numeric constants
`default_nettype none

package masx_pkg;

	// operation codes carried in the command word
	typedef enum logic [2:0] {
		masx_nop = 3'h0,
		masx_nibble_exchange_op = 3'h1,
		masx_literal_minus_acc_op = 3'h2,
		masx_literal_xor_op = 3'h3,
		masx_acc_file_xor_op = 3'h4,
		masx_sleep_op = 3'h5
	} masx_op_t;

	typedef enum logic {
		masx_run = 1'b0,
		masx_asleep = 1'b1
	} masx_state_t;

	// command word, lsb first: op, dest, file address, spare, literal
	typedef struct packed {
		logic [7:0] lit;
		logic [4:0] spare;
		logic [6:0] faddr;
		logic dest;
		masx_op_t op;
	} masx_cmd_t;

	typedef struct packed {
		logic time_out_flag;
		logic power_down_flag;
		logic zero_flag;
		logic nibble_carry_flag;
		logic carry_flag;
	} masx_flags_t;

endpackage : masx_pkg

`default_nettype wire

// ### masx_tb.sv
// tb: self-checking bench for masx_core, driven over its avalon-mm slave port
// assumes the register map of masx_defs.svh; each access waits for waitrequest low
`include "masx_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [`MASX_ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = '0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic sleep_o;
	logic osc_en_o;
	logic wdt_timeout_o;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	longint t0;
	// op, acc before, literal, acc after, low flags after (flags preset to 3)
	localparam logic [39:0] vec [5] = '{40'h0205050007, 40'h020605ff00, 40'h0210312103,
		40'h035a5a0007, 40'h035a81db03};

	// free-running core clock, 8 ns
	always #4 mclk_i = ~mclk_i;

	// small watchdog so an expiry fits in the run: 256 cycles
	masx_core #(.PRE_W(4), .WDT_W(4), .FILE_DEPTH(128)) dut (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.sleep_o(sleep_o),
		.osc_en_o(osc_en_o),
		.wdt_timeout_o(wdt_timeout_o)
	);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one access; request held until the rising edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 20);
		if (k >= 20) begin
			num_errors++;
			$display("MISMATCH at %0t: bus access never acknowledged", $time);
			give_verdict();
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr_reg

	task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd_chk

	task automatic do_cmd(input masx_pkg::masx_op_t op, input logic de, input logic [6:0] fa,
		input logic [7:0] k);
		wr_reg(`MASX_OFF_CMD, {8'h00, k, 5'h00, fa, de, op});
	endtask : do_cmd

	// bounded wait for the watchdog pulse, cycles counted in c
	task automatic wdt_wait(output int c);
		c = 0;
		do begin
			@(negedge mclk_i);
			c++;
		end while (wdt_timeout_o !== 1'b1 && c < 400);
		if (c >= 400) begin
			num_errors++;
			$display("MISMATCH at %0t: watchdog pulse never came", $time);
			give_verdict();
		end
	endtask : wdt_wait

	function automatic logic [9:0] fadr(input logic [6:0] i);
		return {1'b1, i, 2'b00};
	endfunction : fadr

	// main sequence; checks before the first wdt_wait must land before the first watchdog expiry
	initial begin
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(negedge mclk_i);
		chk({30'h0, sleep_o, osc_en_o}, 32'h1);
		rd_chk(`MASX_OFF_ACC, 32'h0);
		rd_chk(`MASX_OFF_STATUS, 32'h18);
		rd_chk(10'h100, 32'h0);
		rd_chk(`MASX_OFF_CMD, 32'h0);
		wr_reg(fadr(7'd5), 32'h3c);
		wr_reg(fadr(7'd6), 32'hdb);
		wr_reg(`MASX_OFF_ACC, 32'h0f);
		wr_reg(`MASX_OFF_STATUS, 32'h5);
		do_cmd(masx_pkg::masx_nibble_exchange_op, `MASX_DEST_ACC, 7'd5, 8'h00);
		rd_chk(`MASX_OFF_ACC, 32'hc3);
		rd_chk(`MASX_OFF_STATUS, 32'h1d);
		rd_chk(fadr(7'd5), 32'h3c);
		// a no-operation code must touch neither destination
		do_cmd(masx_pkg::masx_nop, `MASX_DEST_FILE, 7'd5, 8'hff);
		rd_chk(fadr(7'd5), 32'h3c);
		rd_chk(`MASX_OFF_ACC, 32'hc3);
		wr_reg(fadr(7'd127), 32'ha5);
		do_cmd(masx_pkg::masx_nibble_exchange_op, `MASX_DEST_FILE, 7'd127, 8'h00);
		rd_chk(fadr(7'd127), 32'h5a);
		rd_chk(`MASX_OFF_ACC, 32'hc3);
		// subtract and literal xor cases from the table
		for (int i = 0; i < 5; i++) begin
			wr_reg(`MASX_OFF_ACC, {24'h0, vec[i][31:24]});
			wr_reg(`MASX_OFF_STATUS, 32'h3);
			do_cmd(masx_pkg::masx_op_t'(vec[i][34:32]), `MASX_DEST_ACC, 7'd0, vec[i][23:16]);
			rd_chk(`MASX_OFF_ACC, {24'h0, vec[i][15:8]});
			rd_chk(`MASX_OFF_STATUS, {24'h0, vec[i][7:0]} | 32'h18);
		end
		do_cmd(masx_pkg::masx_acc_file_xor_op, `MASX_DEST_FILE, 7'd5, 8'h00);
		rd_chk(fadr(7'd5), 32'he7);
		rd_chk(`MASX_OFF_ACC, 32'hdb);
		rd_chk(`MASX_OFF_STATUS, 32'h1b);
		do_cmd(masx_pkg::masx_acc_file_xor_op, `MASX_DEST_ACC, 7'd6, 8'h00);
		rd_chk(`MASX_OFF_ACC, 32'h0);
		rd_chk(`MASX_OFF_STATUS, 32'h1f);
		// expiry clears the time-out flag, then sleep sets it again
		wdt_wait(n);
		rd_chk(`MASX_OFF_STATUS, 32'h0f);
		do_cmd(masx_pkg::masx_sleep_op, `MASX_DEST_ACC, 7'd0, 8'h00);
		t0 = $time;
		@(negedge mclk_i);
		chk({30'h0, sleep_o, osc_en_o}, 32'h2);
		rd_chk(`MASX_OFF_STATUS, 32'h17);
		do_cmd(masx_pkg::masx_literal_xor_op, `MASX_DEST_ACC, 7'd0, 8'hff);
		rd_chk(`MASX_OFF_ACC, 32'h0);
		// a cleared watchdog needs a full period, not the remainder
		wdt_wait(n);
		n = int'(($time - t0) / 8);
		chk({31'h0, n >= 253 && n <= 259}, 32'h1);
		@(negedge mclk_i);
		chk({30'h0, sleep_o, osc_en_o}, 32'h1);
		rd_chk(`MASX_OFF_STATUS, 32'h07);
		do_cmd(masx_pkg::masx_sleep_op, `MASX_DEST_ACC, 7'd0, 8'h00);
		wr_reg(`MASX_OFF_POWER, 32'h1);
		@(negedge mclk_i);
		chk({30'h0, sleep_o, osc_en_o}, 32'h1);
		give_verdict();
	end
endmodule : tb

`default_nettype wire
